//--- rtl/ses_pkg.sv
// Purpose: shared constants and types for the status-event block
// Assumes: 8-bit event and enable registers, three-digit BCD parameters
// Notes: to_bcd is used by the formatter and by the checks in the top
package ses_pkg;
	localparam int SES_EV_W = 8;
	localparam int SES_BCD_W = 12;
	localparam logic [7:0] SES_MASK_RST = 8'h00;
	localparam logic [7:0] SES_EVENT_RST = 8'h00;
	localparam logic [9:0] SES_MASK_MAX = 10'h0ff;
	localparam int SES_QUERY_ERR_BIT = 2;
	localparam int SES_SYNTAX_ERR_BIT = 5;
	localparam int SES_STB_SUMMARY_BIT = 5;

	typedef enum logic [2:0]
	{
		SES_OP_NOP = 3'h0,
		SES_OP_CLS = 3'h1,
		SES_OP_MASK_SET = 3'h2,
		SES_OP_MASK_QRY = 3'h3,
		SES_OP_EVENT_QRY = 3'h4
	} ses_op_t;

	// double dabble, 8-bit binary to three BCD digits
	function automatic logic [11:0] to_bcd(input logic [7:0] bin);
		logic [19:0] sh;
		sh = {12'h000, bin};
		for (int i = 0; i < 8; i++)
		begin
			if (sh[11:8] > 4'h4)
				sh[11:8] = sh[11:8] + 4'h3;
			if (sh[15:12] > 4'h4)
				sh[15:12] = sh[15:12] + 4'h3;
			if (sh[19:16] > 4'h4)
				sh[19:16] = sh[19:16] + 4'h3;
			sh = {sh[18:0], 1'b0};
		end
		return sh[19:8];
	endfunction : to_bcd
endpackage : ses_pkg

//--- rtl/ses_bcd_parse.sv
// Purpose: turn a three-digit decimal parameter into a binary weight value
// Assumes: digits arrive as BCD, hundreds in the top nibble
// Notes: purely combinational; digit_ok drops on any nibble above nine
`timescale 1ns/10ps
`default_nettype none
module ses_bcd_parse
	import ses_pkg::*;
(
	input wire logic [11:0] bcd,
	output logic [9:0] bin,
	output logic digit_ok
);
	always_comb
	begin
		bin = 10'(bcd[11:8]) * 10'd100 + 10'(bcd[7:4]) * 10'd10 + 10'(bcd[3:0]);
		digit_ok = (bcd[11:8] < 4'ha) && (bcd[7:4] < 4'ha) && (bcd[3:0] < 4'ha);
	end
endmodule : ses_bcd_parse
`default_nettype wire

//--- rtl/ses_bcd_format.sv
// Purpose: format an 8-bit register value as three decimal digits
// Assumes: caller registers the result
// Notes: combinational wrapper around the shared converter
`timescale 1ns/10ps
`default_nettype none
module ses_bcd_format
	import ses_pkg::*;
(
	input wire logic [7:0] bin,
	output logic [11:0] bcd
);
	always_comb
	begin
		bcd = to_bcd(bin);
	end
endmodule : ses_bcd_format
`default_nettype wire

//--- rtl/ses_status_event.sv
// Purpose: standard event register, its enable mask and the summary bit
// Assumes: commands arrive decoded, one per cmd_valid cycle, synchronous to mclk
// Notes: every command is finished in the cycle after it is taken
`timescale 1ns/10ps
`default_nettype none
module ses_status_event
	import ses_pkg::*;
#(
	parameter int EV_W = SES_EV_W
)
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_op,
	input wire logic [11:0] cmd_bcd,
	input wire logic cmd_after_term,
	input wire logic ev_query_err,
	input wire logic ev_syntax_err,
	input wire logic [7:0] ev_other,
	output logic rsp_valid,
	output logic [11:0] rsp_bcd,
	output logic param_err,
	output logic stb_summary,
	output logic clr_ext_event,
	output logic clr_err_queue,
	output logic clr_out_queue,
	output logic [7:0] mask_state,
	output logic [7:0] event_state
);
	if (EV_W != 8)
	begin : g_width_check
		$error("ses_status_event: only an 8-bit event register is supported");
	end

	typedef struct packed
	{
		logic [7:0] mask;
		logic [7:0] events;
		logic summary;
		logic rsp_valid;
		logic [11:0] rsp_bcd;
		logic param_err;
		logic clr_ext;
		logic clr_err;
		logic clr_out;
	} ses_state_t;

	localparam ses_state_t SES_STATE_RST = '{
		mask: SES_MASK_RST,
		events: SES_EVENT_RST,
		summary: 1'b0,
		rsp_valid: 1'b0,
		rsp_bcd: 12'h000,
		param_err: 1'b0,
		clr_ext: 1'b0,
		clr_err: 1'b0,
		clr_out: 1'b0
	};

	ses_state_t st_r;
	ses_state_t st_nxt;
	logic [9:0] par_bin;
	logic par_ok;
	logic [11:0] mask_bcd;
	logic [11:0] event_bcd;
	logic [7:0] ev_in;
	ses_op_t op;

	ses_bcd_parse u_parse
	(
		.bcd(cmd_bcd),
		.bin(par_bin),
		.digit_ok(par_ok)
	);

	ses_bcd_format u_fmt_mask
	(
		.bin(st_r.mask),
		.bcd(mask_bcd)
	);

	ses_bcd_format u_fmt_event
	(
		.bin(st_r.events),
		.bcd(event_bcd)
	);

	always_comb
	begin
		op = ses_op_t'(cmd_op);
		ev_in = ev_other;
		ev_in[SES_QUERY_ERR_BIT] = ev_other[SES_QUERY_ERR_BIT] | ev_query_err;
		ev_in[SES_SYNTAX_ERR_BIT] = ev_other[SES_SYNTAX_ERR_BIT] | ev_syntax_err;
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rsp_valid = 1'b0;
		st_nxt.param_err = 1'b0;
		st_nxt.clr_ext = 1'b0;
		st_nxt.clr_err = 1'b0;
		st_nxt.clr_out = 1'b0;
		st_nxt.events = st_r.events | ev_in;
		if (cmd_valid)
		begin
			unique case (op)
				SES_OP_CLS:
				begin
					// new events of this cycle survive the clear
					st_nxt.events = ev_in;
					st_nxt.clr_ext = 1'b1;
					st_nxt.clr_err = 1'b1;
					st_nxt.clr_out = cmd_after_term;
				end
				SES_OP_MASK_SET:
				begin
					// out of range or bad digit keeps the old mask
					if (par_ok && par_bin <= SES_MASK_MAX)
						st_nxt.mask = par_bin[7:0];
					else
						st_nxt.param_err = 1'b1;
				end
				SES_OP_MASK_QRY:
				begin
					st_nxt.rsp_valid = 1'b1;
					st_nxt.rsp_bcd = mask_bcd;
				end
				SES_OP_EVENT_QRY:
				begin
					st_nxt.rsp_valid = 1'b1;
					st_nxt.rsp_bcd = event_bcd;
					st_nxt.events = ev_in;
				end
				default:
				begin
					st_nxt.events = st_r.events | ev_in;
				end
			endcase
		end
		st_nxt.summary = |(st_nxt.events & st_nxt.mask);
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			st_r <= SES_STATE_RST;
		else
			st_r <= st_nxt;
	end

	assign rsp_valid = st_r.rsp_valid;
	assign rsp_bcd = st_r.rsp_bcd;
	assign param_err = st_r.param_err;
	assign stb_summary = st_r.summary;
	assign clr_ext_event = st_r.clr_ext;
	assign clr_err_queue = st_r.clr_err;
	assign clr_out_queue = st_r.clr_out;
	assign mask_state = st_r.mask;
	assign event_state = st_r.events;

	mask_query_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_MASK_QRY |=> $stable(mask_state)
			&& rsp_valid && rsp_bcd == to_bcd(mask_state))
		else $error("mask changed or wrong reply on mask query");

	mask_load_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_MASK_SET && cmd_bcd == 12'h251
			|=> mask_state == 8'hfb && !param_err)
		else $error("decimal 251 did not load 11111011");

	mask_range_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_MASK_SET && cmd_bcd == 12'h256
			|=> $stable(mask_state) && param_err)
		else $error("out of range mask value accepted");

	summary_tie_a: assert property (@(posedge mclk) disable iff (!rstn)
		stb_summary == |(event_state & mask_state))
		else $error("summary bit disagrees with enabled events");

	query_err_set_a: assert property (@(posedge mclk) disable iff (!rstn)
		ev_query_err |=> event_state[SES_QUERY_ERR_BIT])
		else $error("query error did not set event bit 2");

	syntax_err_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		ev_syntax_err && ev_other == 8'h00 && !ev_query_err
			##1 cmd_valid && cmd_op == SES_OP_EVENT_QRY && $past(event_state) == 8'h00
			|=> rsp_bcd == 12'h032)
		else $error("lone syntax error did not read back as 32");

	event_read_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_EVENT_QRY && ev_other == 8'h00
			&& !ev_query_err && !ev_syntax_err
			|=> rsp_valid && rsp_bcd == to_bcd($past(event_state)) && event_state == 8'h00)
		else $error("event query reply or clear wrong");

	cls_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_CLS && ev_other == 8'h00
			&& !ev_query_err && !ev_syntax_err
			|=> event_state == 8'h00 && clr_ext_event && clr_err_queue
			##1 !clr_ext_event && !clr_err_queue)
		else $error("clear-status did not clear as expected");

	out_queue_clr_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_CLS |=> clr_out_queue == $past(cmd_after_term))
		else $error("output queue clear wrong for clear-status");

	clear_keeps_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && (cmd_op == SES_OP_CLS || cmd_op == SES_OP_EVENT_QRY)
			|=> $stable(mask_state) && stb_summary == |(event_state & mask_state))
		else $error("clear touched the mask or left a stale summary");

	reset_values_a: assert property (@(posedge mclk)
		$rose(rstn) |-> mask_state == SES_MASK_RST && !stb_summary && !rsp_valid)
		else $error("enable mask or summary not clear after reset");

	mask_set_value_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_MASK_SET
			|=> param_err || to_bcd(mask_state) == $past(cmd_bcd))
		else $error("stored mask does not read back as the written value");

	bad_digit_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_MASK_SET
			&& (cmd_bcd[3:0] > 4'h9 || cmd_bcd[7:4] > 4'h9 || cmd_bcd[11:8] > 4'h9)
			|=> param_err && $stable(mask_state))
		else $error("mask parameter with a bad digit was accepted");

	mask_only_set_a: assert property (@(posedge mclk) disable iff (!rstn)
		!(cmd_valid && cmd_op == SES_OP_MASK_SET) |=> $stable(mask_state))
		else $error("enable mask changed without a mask write");

	param_err_only_a: assert property (@(posedge mclk) disable iff (!rstn)
		!(cmd_valid && cmd_op == SES_OP_MASK_SET) |=> !param_err)
		else $error("parameter error raised without a mask write");

	reply_only_query_a: assert property (@(posedge mclk) disable iff (!rstn)
		!(cmd_valid && (cmd_op == SES_OP_MASK_QRY || cmd_op == SES_OP_EVENT_QRY))
			|=> !rsp_valid && $stable(rsp_bcd))
		else $error("reply changed without a query");

	event_reply_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_EVENT_QRY
			|=> rsp_valid && rsp_bcd == to_bcd($past(event_state)))
		else $error("event query did not return the register as decimal");

	clr_only_cls_a: assert property (@(posedge mclk) disable iff (!rstn)
		!(cmd_valid && cmd_op == SES_OP_CLS)
			|=> !clr_ext_event && !clr_err_queue && !clr_out_queue)
		else $error("clear pulse without a clear-status command");

	out_clr_with_cls_a: assert property (@(posedge mclk) disable iff (!rstn)
		clr_out_queue |-> clr_ext_event && clr_err_queue)
		else $error("output queue cleared outside a clear-status");

	event_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
		!(cmd_valid && (cmd_op == SES_OP_CLS || cmd_op == SES_OP_EVENT_QRY))
			|=> (event_state & $past(event_state)) == $past(event_state))
		else $error("event bit dropped without a clear");

	// bit 2 stays out of the summary while its enable is clear
	masked_event_a: assert property (@(posedge mclk) disable iff (!rstn)
		ev_query_err && !mask_state[SES_QUERY_ERR_BIT] && !stb_summary && !cmd_valid
			&& !ev_syntax_err && ev_other == 8'h00 |=> !stb_summary)
		else $error("masked query error raised the summary bit");

	enabled_event_a: assert property (@(posedge mclk) disable iff (!rstn)
		ev_syntax_err && mask_state[SES_SYNTAX_ERR_BIT] && !cmd_valid |=> stb_summary)
		else $error("enabled syntax error did not raise the summary bit");

	// set wins: an event in a clear cycle is kept
	other_event_set_a: assert property (@(posedge mclk) disable iff (!rstn)
		ev_other != 8'h00 |=> (event_state & $past(ev_other)) == $past(ev_other))
		else $error("event arriving with a clear was lost");

	summary_after_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_EVENT_QRY && ev_other == 8'h00
			&& !ev_query_err && !ev_syntax_err |=> !stb_summary)
		else $error("summary bit left set after the register was read");

	mask_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && cmd_op == SES_OP_MASK_SET && cmd_bcd == 12'h000
			|=> mask_state == 8'h00 && !stb_summary)
		else $error("zero mask left the summary bit set");

	nop_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_valid && (cmd_op == SES_OP_NOP || cmd_op > 3'h4)
			|=> !rsp_valid && !param_err && !clr_ext_event && $stable(mask_state))
		else $error("idle or unknown command had an effect");
endmodule : ses_status_event
`default_nettype wire

//--- verif/ses_host.sv
// Purpose: host model issuing decoded status-event commands
// Assumes: one command per send, driven after the next mclk rising edge and taken on the edge after that
// Notes: parameter bus shows the inverse once released
`timescale 1ns/10ps
`default_nettype none
module ses_host
	import ses_pkg::*;
(
	input wire logic mclk,
	output logic cmd_valid,
	output logic [2:0] cmd_op,
	output logic [11:0] cmd_bcd,
	output logic cmd_after_term
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_op = 3'h0;
		cmd_bcd = 12'h000;
		cmd_after_term = 1'b0;
	end
	// decimal 0 to 255 unless the caller means a refusal
	task automatic send(input ses_op_t op, input logic [11:0] bcd, input logic term);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_bcd <= bcd;
		cmd_after_term <= term;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_bcd <= ~bcd;
		#1;
	endtask : send
endmodule : ses_host
`default_nettype wire

//--- verif/testbench.sv
// Purpose: self-checking bench for the status-event block
// Assumes: host model drives commands, bench drives event sources
// Notes: other event sources are driven in the set-wins scenario only
`timescale 1ns/10ps
`default_nettype none
module testbench
	import ses_pkg::*;
;
	logic mclk, rstn, ev_query_err, ev_syntax_err;
	wire logic cmd_valid, cmd_after_term;
	wire logic [2:0] cmd_op;
	wire logic [11:0] cmd_bcd;
	logic rsp_valid, param_err, stb_summary, clr_ext_event, clr_err_queue, clr_out_queue;
	logic [11:0] rsp_bcd;
	logic [7:0] mask_state, event_state, ev_other;
	int fail_count = 0;
	int total_checks = 0;
	ses_host i_ses_host (.mclk, .cmd_valid, .cmd_op, .cmd_bcd, .cmd_after_term);
	ses_status_event i_ses_status_event (.mclk, .rstn, .cmd_valid, .cmd_op, .cmd_bcd,
		.cmd_after_term, .ev_query_err, .ev_syntax_err, .ev_other, .rsp_valid,
		.rsp_bcd, .param_err, .stb_summary, .clr_ext_event, .clr_err_queue,
		.clr_out_queue, .mask_state, .event_state);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
		total_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic ev(input logic q, input logic s, input logic [7:0] o);
		@(posedge mclk);
		ev_query_err <= q;
		ev_syntax_err <= s;
		ev_other <= o;
		@(posedge mclk);
		ev_query_err <= 1'b0;
		ev_syntax_err <= 1'b0;
		ev_other <= 8'h00;
		#1;
	endtask : ev
	// command and event taken on the same edge
	task automatic cmd_ev(input ses_op_t op, input logic q, input logic [7:0] o);
		fork
			i_ses_host.send(op, 12'h000, 1'b0);
			ev(q, 1'b0, o);
		join
	endtask : cmd_ev
	task automatic t_reset();
		chk("mask", 12'(mask_state), 12'h000);
		chk("summary", 12'(stb_summary), 12'h000);
	endtask : t_reset
	task automatic t_mask();
		i_ses_host.send(SES_OP_MASK_SET, 12'h251, 1'b0);
		chk("mask", 12'(mask_state), 12'h0fb);
		chk("param_err", 12'(param_err), 12'h000);
		i_ses_host.send(SES_OP_MASK_QRY, 12'h000, 1'b0);
		chk("rsp_valid", 12'(rsp_valid), 12'h001);
		chk("rsp", rsp_bcd, 12'h251);
		chk("mask", 12'(mask_state), 12'h0fb);
		i_ses_host.send(SES_OP_MASK_SET, 12'h256, 1'b0);
		chk("param_err", 12'(param_err), 12'h001);
		chk("mask", 12'(mask_state), 12'h0fb);
		i_ses_host.send(SES_OP_MASK_SET, 12'h0fa, 1'b0);
		chk("param_err", 12'(param_err), 12'h001);
		chk("mask", 12'(mask_state), 12'h0fb);
	endtask : t_mask
	task automatic t_events();
		ev(1'b0, 1'b1, 8'h00);
		chk("event", 12'(event_state), 12'h020);
		chk("summary", 12'(stb_summary), 12'h001);
		i_ses_host.send(SES_OP_EVENT_QRY, 12'h000, 1'b0);
		chk("rsp", rsp_bcd, 12'h032);
		chk("event", 12'(event_state), 12'h000);
		chk("summary", 12'(stb_summary), 12'h000);
		ev(1'b1, 1'b0, 8'h00);
		chk("event", 12'(event_state), 12'h004);
		chk("summary", 12'(stb_summary), 12'h000);
	endtask : t_events
	task automatic t_clear();
		for (int t = 1; t >= 0; t--)
		begin
			i_ses_host.send(SES_OP_CLS, 12'h000, 1'(t));
			chk("ext_clr", 12'(clr_ext_event), 12'h001);
			chk("err_clr", 12'(clr_err_queue), 12'h001);
			chk("out_clr", 12'(clr_out_queue), 12'(t));
			chk("event", 12'(event_state), 12'h000);
			chk("mask", 12'(mask_state), 12'h0fb);
		end
	endtask : t_clear
	// syntax error lands one cycle before the query that reads it
	task automatic t_adjacent();
		@(posedge mclk);
		ev_syntax_err <= 1'b1;
		fork
			i_ses_host.send(SES_OP_EVENT_QRY, 12'h000, 1'b0);
			begin
				@(posedge mclk);
				ev_syntax_err <= 1'b0;
			end
		join
		chk("rsp", rsp_bcd, 12'h032);
		chk("event", 12'(event_state), 12'h000);
	endtask : t_adjacent
	task automatic t_wins();
		cmd_ev(SES_OP_CLS, 1'b1, 8'h00);
		chk("event", 12'(event_state), 12'h004);
		chk("out_clr", 12'(clr_out_queue), 12'h000);
		cmd_ev(SES_OP_EVENT_QRY, 1'b0, 8'h80);
		chk("rsp", rsp_bcd, 12'h004);
		chk("event", 12'(event_state), 12'h080);
		chk("summary", 12'(stb_summary), 12'h001);
		cmd_ev(SES_OP_EVENT_QRY, 1'b0, 8'h01);
		chk("rsp", rsp_bcd, 12'h128);
		chk("event", 12'(event_state), 12'h001);
		chk("summary", 12'(stb_summary), 12'h001);
		i_ses_host.send(SES_OP_MASK_SET, 12'h000, 1'b0);
		chk("mask", 12'(mask_state), 12'h000);
		chk("summary", 12'(stb_summary), 12'h000);
		i_ses_host.send(SES_OP_MASK_QRY, 12'h000, 1'b0);
		chk("rsp", rsp_bcd, 12'h000);
		chk("event", 12'(event_state), 12'h001);
	endtask : t_wins
	task automatic t_nop();
		i_ses_host.send(SES_OP_NOP, 12'h000, 1'b0);
		chk("rsp_valid", 12'(rsp_valid), 12'h000);
		i_ses_host.send(ses_op_t'(3'h7), 12'h999, 1'b1);
		chk("out_clr", 12'(clr_out_queue), 12'h000);
		chk("param_err", 12'(param_err), 12'h000);
		chk("mask", 12'(mask_state), 12'h000);
		chk("event", 12'(event_state), 12'h001);
	endtask : t_nop
	task automatic t_rst_again();
		i_ses_host.send(SES_OP_MASK_SET, 12'h255, 1'b0);
		chk("mask", 12'(mask_state), 12'h0ff);
		chk("summary", 12'(stb_summary), 12'h001);
		@(posedge mclk);
		rstn <= 1'b0;
		@(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		#1;
		chk("mask", 12'(mask_state), 12'h000);
		chk("summary", 12'(stb_summary), 12'h000);
		i_ses_host.send(SES_OP_MASK_QRY, 12'h000, 1'b0);
		chk("rsp", rsp_bcd, 12'h000);
	endtask : t_rst_again
	initial
	begin
		ev_query_err = 1'b0;
		ev_syntax_err = 1'b0;
		ev_other = 8'h00;
		rstn = 1'b0;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		#1;
		t_reset();
		t_mask();
		t_events();
		t_clear();
		t_adjacent();
		t_wins();
		t_nop();
		t_rst_again();
		test_done();
	end
	// whole run is well under two hundred cycles
	initial
	begin
		repeat (2000) @(posedge mclk);
		fail_count++;
		test_done();
	end
endmodule : testbench
`default_nettype wire
